// file: rtl/bng_pkg.sv
// Operation
// - Overcurrent threshold code gives percent offset from nominal
// - Shutdown on brownout enable, resets disabled
// - Hold-clear write releases infinite hold, self-clears
// - Infinite hold waits for clear, else timed hold
// - Mute-on-brownout mutes then shuts down
// - Brownout prevention enable resets to enabled
// - Attack rate: one step per 2^n samples
// - Attack step 0.5 to 2 dB, reset 1 dB
// - Hold time table 0 to 1000 ms, reset 500
// - Lowest-mode signalling threshold field, reset code 3
// - Gate entry hysteresis table, reset 50 ms
// - Gate threshold -90 to -120 dBFS, reset -120
// - Gate enable bit 2, resets enabled
// - Gate ramp control inverted, resets disabled
// - Supply-switch hysteresis codes A-F, reset 50 ms
// - Supply hysteresis counts samples, scales with rate
// - Infinite hold entry latched in maskable status
package bng_pkg;
   localparam logic [7:0] ADDR_OC_BOP = 8'h1F;
   localparam logic [7:0] ADDR_BOP_TIMING = 8'h20;
   localparam logic [7:0] ADDR_LOWSIG_LOW = 8'h34;
   localparam logic [7:0] ADDR_GATE_CFG = 8'h35;
   localparam logic [7:0] ADDR_RAMP_HYST = 8'h36;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h3B;
   localparam logic [7:0] ADDR_IRQ_LATCH = 8'h42;

   localparam logic [7:0] RST_OC_BOP = 8'h01;
   localparam logic [7:0] RST_BOP_TIMING = 8'h2E;
   localparam logic [7:0] RST_LOWSIG_LOW = 8'h06;
   localparam logic [7:0] RST_GATE_CFG = 8'hBD;
   localparam logic [7:0] RST_RAMP_HYST = 8'hAD;
   localparam logic [7:0] RST_IRQ_MASK = 8'hFC;

   // Field positions
   localparam int OC_THR_LSB = 5;
   localparam int BOP_SD_BIT = 4;
   localparam int BOP_CLR_BIT = 3;
   localparam int BOP_INF_BIT = 2;
   localparam int BOP_MUTE_BIT = 1;
   localparam int BOP_EN_BIT = 0;
   localparam int ATK_RT_LSB = 5;
   localparam int ATK_ST_LSB = 3;
   localparam int HOLD_LSB = 0;
   localparam int LOWSIG_LSB = 1;
   localparam int GATE_HYST_LSB = 5;
   localparam int GATE_TH_LSB = 3;
   localparam int GATE_EN_BIT = 2;
   localparam logic [1:0] GATE_RSVD_VAL = 2'h1;
   localparam int RAMP_RSVD_LSB = 6;
   localparam int RAMP_DIS_BIT = 5;
   localparam int SUP_HYST_LSB = 0;
   localparam int INF_IRQ_BIT = 6;
   localparam logic [3:0] SUP_HYST_FIRST = 4'hA;

   // Times in their own units
   localparam int HOLD_MS [8] = '{0, 10, 25, 50, 100, 250, 500, 1000};
   localparam int GATE_HYST_US [8] = '{400, 600, 800, 2000, 10000, 50000, 100000, 1000000};
   localparam int SUP_HYST_MS [6] = '{1, 10, 20, 50, 75, 100};
   localparam int US_PER_MS = 1000;
   localparam int BASE_RATE_KSPS = 48;
   localparam int CNT_W = 17;

   // Overcurrent offsets in percent of nominal, signed
   localparam logic signed [7:0] OC_PCT [8] = '{8'sh00, 8'sh0A, 8'sh14, 8'sh1E,
                                              -8'sh28, -8'sh1E, -8'sh14, -8'sh0A};

   typedef enum logic [2:0] {BNG_IDLE, BNG_ATTACK, BNG_HOLD, BNG_INF_HOLD, BNG_MUTE, BNG_SHUT} bng_bop_t;

   // Least time: rounds up to whole samples, never below one
   function automatic logic [CNT_W-1:0] bng_us_to_samples(input int us, input int rate_ksps);
      int n;
      n = (us * rate_ksps + US_PER_MS - 1) / US_PER_MS;
      if (n < 1)
      begin
         n = 1;
      end
      return CNT_W'(n);
   endfunction : bng_us_to_samples
endpackage : bng_pkg

// file: rtl/bng_regs.sv
`timescale 1ns/1ns
`default_nettype none
module bng_regs
   import bng_pkg::*;
#(
   parameter int RATE_KSPS = BASE_RATE_KSPS
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sample_tick,
   input wire logic brownout_detect,
   input wire logic gate_below_threshold,
   input wire logic low_supply_request,
   output logic signed [7:0] high_side_overcurrent_threshold,
   output logic [2:0] gate_threshold,
   output logic [1:0] low_signal_threshold_lowest_mode,
   output logic gate_volume_ramp_disable,
   output logic gain_step,
   output logic [2:0] gain_step_half_db,
   output logic gain_reduction_active,
   output logic audio_mute,
   output logic shutdown_request,
   output logic gate_active,
   output logic use_low_supply,
   output logic infinite_hold_irq
);
   generate
      if (RATE_KSPS < 1 || RATE_KSPS > BASE_RATE_KSPS)
      begin : g_bad_rate
         $error("RATE_KSPS out of range");
      end
   endgenerate

   typedef struct packed {
      logic [7:0] oc_bop;
      logic [7:0] timing;
      logic [1:0] lowsig;
      logic [7:0] gate;
      logic [7:0] ramp;
      logic irq_mask;
      logic irq_latch;
      logic [7:0] rdata;
      bng_bop_t bop;
      logic [CNT_W-1:0] bop_cnt;
      logic [CNT_W-1:0] gate_cnt;
      logic [CNT_W-1:0] sup_cnt;
      logic signed [7:0] oc_pct;
      logic step;
      logic [2:0] step_half_db;
      logic reduce;
      logic mute;
      logic shut;
      logic gate_on;
      logic low_sup;
      logic irq;
   } bng_state_t;

   localparam bng_state_t RST = '{oc_bop: RST_OC_BOP, timing: RST_BOP_TIMING,
      lowsig: RST_LOWSIG_LOW[LOWSIG_LSB +: 2], gate: RST_GATE_CFG, ramp: RST_RAMP_HYST,
      irq_mask: RST_IRQ_MASK[INF_IRQ_BIT], irq_latch: 1'b0, rdata: 8'h00, bop: BNG_IDLE,
      bop_cnt: '0, gate_cnt: '0, sup_cnt: '0, oc_pct: 8'sh00, step: 1'b0,
      step_half_db: 3'h2, reduce: 1'b0, mute: 1'b0, shut: 1'b0, gate_on: 1'b0,
      low_sup: 1'b0, irq: 1'b0};

   bng_state_t s_q;
   bng_state_t s_d;

   logic [2:0] atk_rate;
   logic [2:0] hold_code;
   logic [2:0] gate_hyst_code;
   logic [3:0] sup_code;
   logic [CNT_W-1:0] atk_samples;
   logic [CNT_W-1:0] hold_samples;
   logic [CNT_W-1:0] gate_samples;
   logic [CNT_W-1:0] sup_samples;
   logic bop_on;
   logic inf_sel;
   logic hold_clr;
   logic wr_oc;

   always_comb
   begin
      atk_rate = s_q.timing[ATK_RT_LSB +: 3];
      hold_code = s_q.timing[HOLD_LSB +: 3];
      gate_hyst_code = s_q.gate[GATE_HYST_LSB +: 3];
      sup_code = s_q.ramp[SUP_HYST_LSB +: 4];
      atk_samples = CNT_W'(1) << atk_rate;
      hold_samples = '0;
      gate_samples = '0;
      sup_samples = '0;
      for (int i = 0; i < 8; i++)
      begin
         if (hold_code == 3'(i))
         begin
            hold_samples = CNT_W'(HOLD_MS[i] * RATE_KSPS);
         end
         if (gate_hyst_code == 3'(i))
         begin
            gate_samples = bng_us_to_samples(GATE_HYST_US[i], RATE_KSPS);
         end
      end
      // Reserved codes fall back to the shortest time rather than leaving the switch stuck
      sup_samples = bng_us_to_samples(SUP_HYST_MS[0] * US_PER_MS, BASE_RATE_KSPS);
      for (int i = 0; i < 6; i++)
      begin
         if (sup_code == SUP_HYST_FIRST + 4'(i))
         begin
            // Counted in samples at the base rate, so slower rates stretch it by 48/fs
            sup_samples = bng_us_to_samples(SUP_HYST_MS[i] * US_PER_MS, BASE_RATE_KSPS);
         end
      end
      bop_on = s_q.oc_bop[BOP_EN_BIT];
      inf_sel = s_q.oc_bop[BOP_INF_BIT];
      hold_clr = s_q.oc_bop[BOP_CLR_BIT];
      wr_oc = reg_wr && reg_addr == ADDR_OC_BOP;
   end

   always_comb
   begin
      s_d = s_q;
      s_d.step = 1'b0;
      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_OC_BOP: s_d.oc_bop = reg_wdata;
            ADDR_BOP_TIMING: s_d.timing = reg_wdata;
            ADDR_LOWSIG_LOW: s_d.lowsig = reg_wdata[LOWSIG_LSB +: 2];
            ADDR_GATE_CFG: s_d.gate = {reg_wdata[7:2], GATE_RSVD_VAL};
            ADDR_RAMP_HYST: s_d.ramp = {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
            ADDR_IRQ_MASK: s_d.irq_mask = reg_wdata[INF_IRQ_BIT];
            default: s_d.rdata = s_q.rdata;
         endcase
      end
      // Clear bit is seen for exactly one cycle by the brownout logic, then dropped
      if (hold_clr && !wr_oc)
      begin
         s_d.oc_bop[BOP_CLR_BIT] = 1'b0;
      end
      // Reads
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_OC_BOP: s_d.rdata = s_q.oc_bop;
            ADDR_BOP_TIMING: s_d.rdata = s_q.timing;
            ADDR_LOWSIG_LOW: s_d.rdata = {5'h00, s_q.lowsig, 1'b0};
            ADDR_GATE_CFG: s_d.rdata = s_q.gate;
            ADDR_RAMP_HYST: s_d.rdata = s_q.ramp;
            ADDR_IRQ_MASK: s_d.rdata = {RST_IRQ_MASK[7], s_q.irq_mask, RST_IRQ_MASK[5:0]};
            ADDR_IRQ_LATCH: s_d.rdata = {1'b0, s_q.irq_latch, 6'h00};
            default: s_d.rdata = 8'h00;
         endcase
         if (reg_addr == ADDR_IRQ_LATCH)
         begin
            s_d.irq_latch = 1'b0;
         end
      end
      // Brownout state machine
      case (s_q.bop)
         BNG_IDLE:
         begin
            s_d.bop_cnt = '0;
            if (bop_on && brownout_detect)
            begin
               if (s_q.oc_bop[BOP_MUTE_BIT])
               begin
                  s_d.bop = BNG_MUTE;
               end
               else if (s_q.oc_bop[BOP_SD_BIT])
               begin
                  s_d.bop = BNG_SHUT;
               end
               else
               begin
                  s_d.bop = BNG_ATTACK;
               end
            end
         end
         BNG_ATTACK:
         begin
            if (!brownout_detect)
            begin
               s_d.bop_cnt = '0;
               if (inf_sel)
               begin
                  s_d.bop = BNG_INF_HOLD;
                  s_d.irq_latch = 1'b1;
               end
               else
               begin
                  s_d.bop = BNG_HOLD;
               end
            end
            else if (sample_tick)
            begin
               if (s_q.bop_cnt + CNT_W'(1) >= atk_samples)
               begin
                  s_d.bop_cnt = '0;
                  s_d.step = 1'b1;
               end
               else
               begin
                  s_d.bop_cnt = s_q.bop_cnt + CNT_W'(1);
               end
            end
         end
         BNG_HOLD:
         begin
            if (brownout_detect)
            begin
               s_d.bop = BNG_ATTACK;
               s_d.bop_cnt = '0;
            end
            else if (s_q.bop_cnt >= hold_samples)
            begin
               s_d.bop = BNG_IDLE;
            end
            else if (sample_tick)
            begin
               s_d.bop_cnt = s_q.bop_cnt + CNT_W'(1);
            end
         end
         BNG_INF_HOLD:
         begin
            if (hold_clr)
            begin
               s_d.bop = BNG_IDLE;
            end
         end
         BNG_MUTE:
         begin
            // Silence until the next sample tick before the power stage goes down avoids a pop
            if (sample_tick)
            begin
               s_d.bop = BNG_SHUT;
            end
         end
         BNG_SHUT: s_d.bop = BNG_SHUT;
         default: s_d.bop = BNG_IDLE;
      endcase
      if (!bop_on)
      begin
         s_d.bop = BNG_IDLE;
      end
      // Noise gate entry: level must stay low for the whole hysteresis time
      if (s_q.gate[GATE_EN_BIT] && gate_below_threshold)
      begin
         if (s_q.gate_cnt >= gate_samples)
         begin
            s_d.gate_on = 1'b1;
         end
         else if (sample_tick)
         begin
            s_d.gate_cnt = s_q.gate_cnt + CNT_W'(1);
         end
      end
      else
      begin
         s_d.gate_cnt = '0;
         s_d.gate_on = 1'b0;
      end
      // High to low supply only after the hysteresis time; back to high at once
      if (low_supply_request)
      begin
         if (s_q.sup_cnt >= sup_samples)
         begin
            s_d.low_sup = 1'b1;
         end
         else if (sample_tick)
         begin
            s_d.sup_cnt = s_q.sup_cnt + CNT_W'(1);
         end
      end
      else
      begin
         s_d.sup_cnt = '0;
         s_d.low_sup = 1'b0;
      end
      // Registered copies of decoded settings and status
      s_d.oc_pct = OC_PCT[s_q.oc_bop[OC_THR_LSB +: 3]];
      s_d.step_half_db = {1'b0, s_q.timing[ATK_ST_LSB +: 2]} + 3'h1;
      s_d.reduce = s_q.bop == BNG_ATTACK || s_q.bop == BNG_HOLD || s_q.bop == BNG_INF_HOLD;
      s_d.mute = s_q.bop == BNG_MUTE || (s_q.bop == BNG_SHUT && s_q.oc_bop[BOP_MUTE_BIT]);
      s_d.shut = s_q.bop == BNG_SHUT;
      s_d.irq = s_q.irq_latch && !s_q.irq_mask;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_q <= RST;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign high_side_overcurrent_threshold = s_q.oc_pct;
   assign gate_threshold = {1'b0, s_q.gate[GATE_TH_LSB +: 2]};
   assign low_signal_threshold_lowest_mode = s_q.lowsig;
   assign gate_volume_ramp_disable = s_q.ramp[RAMP_DIS_BIT];
   assign gain_step = s_q.step;
   assign gain_step_half_db = s_q.step_half_db;
   assign gain_reduction_active = s_q.reduce;
   assign audio_mute = s_q.mute;
   assign shutdown_request = s_q.shut;
   assign gate_active = s_q.gate_on;
   assign use_low_supply = s_q.low_sup;
   assign infinite_hold_irq = s_q.irq;
endmodule : bng_regs
`default_nettype wire

// file: verification/bng_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module bng_regs_monitor
   import bng_pkg::*;
#(
   parameter int RATE_KSPS = BASE_RATE_KSPS
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_tick,
   input wire logic brownout_detect,
   input wire logic gate_below_threshold,
   input wire logic low_supply_request,
   input wire logic signed [7:0] high_side_overcurrent_threshold,
   input wire logic [2:0] gate_threshold,
   input wire logic [1:0] low_signal_threshold_lowest_mode,
   input wire logic gate_volume_ramp_disable,
   input wire logic gain_step,
   input wire logic [2:0] gain_step_half_db,
   input wire logic gain_reduction_active,
   input wire logic audio_mute,
   input wire logic shutdown_request,
   input wire logic gate_active,
   input wire logic use_low_supply,
   input wire logic infinite_hold_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic w_oc = clk_en && reg_wr && reg_addr == ADDR_OC_BOP;
   wire logic w_at = clk_en && reg_wr && reg_addr == ADDR_BOP_TIMING;
   wire logic w_ng = clk_en && reg_wr && reg_addr == ADDR_GATE_CFG;
   wire logic w_rh = clk_en && reg_wr && reg_addr == ADDR_RAMP_HYST;
   oc_map_a: assert property (w_oc ##1 !w_oc |=> high_side_overcurrent_threshold == OC_PCT[$past(reg_wdata[7:5], 2)])
      else $error("overcurrent offset wrong");
   step_size_a: assert property (w_at ##1 !w_at |=> gain_step_half_db == {1'b0, $past(reg_wdata[4:3], 2)} + 3'h1)
      else $error("attack step size wrong");
   gate_thr_a: assert property (w_ng ##1 !w_ng |=> gate_threshold == {1'b0, $past(reg_wdata[4:3], 2)})
      else $error("gate threshold wrong");
   ramp_pol_a: assert property (w_rh ##1 !w_rh |=> gate_volume_ramp_disable == $past(reg_wdata[5], 2))
      else $error("ramp control wrong");
   mute_then_shut_a: assert property ($rose(audio_mute) |-> ##[1:20] shutdown_request)
      else $error("mute not followed by shutdown");
   clear_reads_zero_a: assert property (w_oc && reg_wdata[3] ##3 (clk_en && reg_rd && reg_addr == ADDR_OC_BOP)
      |=> !reg_rdata[3])
      else $error("hold clear did not self clear");
   shut_sticky_a: assert property (shutdown_request && !w_oc && !$past(w_oc) && !$past(w_oc, 2) |=> shutdown_request)
      else $error("shutdown dropped");
   gate_drop_a: assert property (clk_en && !gate_below_threshold |=> !gate_active)
      else $error("gate held without low audio");
   unmapped_zero_a: assert property (clk_en && reg_rd && reg_addr == 8'h21 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property (gain_step);
   cover property ($rose(gate_active));
   cover property ($rose(infinite_hold_irq));
endmodule : bng_regs_monitor
bind bng_regs bng_regs_monitor #(.RATE_KSPS(RATE_KSPS)) mon (.*);
`default_nettype wire

// file: verification/bng_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bng_regs_tb
   import bng_pkg::*;
;
   logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sample_tick = 1'b0;
   logic brownout_detect = 1'b0, gate_below_threshold = 1'b0, low_supply_request = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic signed [7:0] high_side_overcurrent_threshold;
   logic [2:0] gate_threshold, gain_step_half_db;
   logic [1:0] low_signal_threshold_lowest_mode;
   logic gate_volume_ramp_disable, gain_step, gain_reduction_active, audio_mute;
   logic shutdown_request, gate_active, use_low_supply, infinite_hold_irq;
   logic signed [7:0] pct [8] = '{8'sh00, 8'sh0A, 8'sh14, 8'sh1E, -8'sh28, -8'sh1E, -8'sh14, -8'sh0A};
   int fails = 0, comparisons = 0, tk = 0, n;
   // One sample per ms keeps the hold and gate counts used here under a few hundred cycles; the supply count stays at 48 samples per ms
   bng_regs #(.RATE_KSPS(1)) dut (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .sample_tick(sample_tick),
      .brownout_detect(brownout_detect),
      .gate_below_threshold(gate_below_threshold),
      .low_supply_request(low_supply_request),
      .high_side_overcurrent_threshold(high_side_overcurrent_threshold),
      .gate_threshold(gate_threshold),
      .low_signal_threshold_lowest_mode(low_signal_threshold_lowest_mode),
      .gate_volume_ramp_disable(gate_volume_ramp_disable),
      .gain_step(gain_step),
      .gain_step_half_db(gain_step_half_db),
      .gain_reduction_active(gain_reduction_active),
      .audio_mute(audio_mute),
      .shutdown_request(shutdown_request),
      .gate_active(gate_active),
      .use_low_supply(use_low_supply),
      .infinite_hold_irq(infinite_hold_irq)
   );
   initial
   begin
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      tk <= (tk + 1) % 4;
      sample_tick <= (tk == 3);
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(2);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
      chk("rdata", e, reg_rdata);
   endtask : rd
   // Bounded wait; the caller still checks the level or the wait count n afterwards
   task automatic await(input int sel);
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end
      while ((sel == 0 ? gain_step : shutdown_request) !== 1'b1 && n < 300);
   endtask : await
   task automatic t_reset;
      rd(8'h1F, 8'h01);
      rd(8'h20, 8'h2E);
      rd(8'h34, 8'h06);
      rd(8'h35, 8'hBD);
      rd(8'h36, 8'hAD);
      rd(8'h21, 8'h00);
      chk("step", 8'h02, gain_step_half_db);
      chk("gthr", 8'h03, gate_threshold);
      chk("ramp", 8'h01, gate_volume_ramp_disable);
      $display("reset test done");
   endtask : t_reset
   task automatic t_fields;
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h1F, {c[2:0], 5'h01});
         chk("oc", pct[c], high_side_overcurrent_threshold);
         wr(8'h20, {3'h1, c[1:0], 3'h6});
         chk("step", 8'(c[1:0]) + 8'h01, gain_step_half_db);
      end
      wr(8'h34, 8'hFB);
      rd(8'h34, 8'h02);
      chk("lsig", 8'h01, low_signal_threshold_lowest_mode);
      wr(8'h35, 8'h02);
      rd(8'h35, 8'h01);
      chk("gthr", 8'h00, gate_threshold);
      wr(8'h36, 8'h5F);
      rd(8'h36, 8'h4F);
      chk("ramp", 8'h00, gate_volume_ramp_disable);
      // A write while the enable is low must not land
      clk_en <= 1'b0;
      wr(8'h35, 8'hFC);
      clk_en <= 1'b1;
      rd(8'h35, 8'h01);
      $display("field test done");
   endtask : t_fields
   task automatic t_attack;
      wr(8'h20, 8'h59);
      brownout_detect <= 1'b1;
      await(0);
      await(0);
      chk("gap", 8'd16, 8'(n));
      brownout_detect <= 1'b0;
      cyc(30);
      chk("held", 8'h01, gain_reduction_active);
      cyc(20);
      chk("freed", 8'h00, gain_reduction_active);
      $display("attack test done");
   endtask : t_attack
   task automatic t_infhold;
      wr(8'h3B, 8'hBC);
      wr(8'h1F, 8'h05);
      brownout_detect <= 1'b1;
      cyc(8);
      brownout_detect <= 1'b0;
      cyc(100);
      chk("inf", 8'h01, gain_reduction_active);
      chk("irq", 8'h01, infinite_hold_irq);
      wr(8'h1F, 8'h0D);
      rd(8'h1F, 8'h05);
      cyc(2);
      chk("clr", 8'h00, gain_reduction_active);
      rd(8'h42, 8'h40);
      cyc(2);
      chk("irq", 8'h00, infinite_hold_irq);
      $display("infinite hold test done");
   endtask : t_infhold
   task automatic t_mute;
      for (int m = 0; m < 2; m++)
      begin
         wr(8'h1F, m ? 8'h11 : 8'h03);
         brownout_detect <= 1'b1;
         await(1);
         chk("shut", 8'h01, shutdown_request);
         chk("mute", m ? 8'h00 : 8'h01, audio_mute);
         brownout_detect <= 1'b0;
         wr(8'h1F, 8'h00);
         cyc(2);
         chk("shut", 8'h00, shutdown_request);
      end
      brownout_detect <= 1'b1;
      cyc(20);
      chk("off", 8'h00, gain_reduction_active);
      brownout_detect <= 1'b0;
      $display("mute test done");
   endtask : t_mute
   task automatic t_gate;
      wr(8'h35, 8'h9D);
      gate_below_threshold <= 1'b1;
      cyc(30);
      chk("gate", 8'h00, gate_active);
      cyc(20);
      chk("gate", 8'h01, gate_active);
      wr(8'h35, 8'h99);
      cyc(60);
      chk("gate", 8'h00, gate_active);
      gate_below_threshold <= 1'b0;
      wr(8'h36, 8'hAA);
      low_supply_request <= 1'b1;
      cyc(170);
      chk("low", 8'h00, use_low_supply);
      cyc(40);
      chk("low", 8'h01, use_low_supply);
      low_supply_request <= 1'b0;
      $display("gate and supply test done");
   endtask : t_gate
   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial
   begin
      cyc(20000);
      fails++;
      finish_test();
   end
   initial
   begin
      cyc(5);
      reset <= 1'b0;
      cyc(1);
      t_reset();
      t_fields();
      t_attack();
      t_infhold();
      t_mute();
      t_gate();
      finish_test();
   end
endmodule : bng_regs_tb
`default_nettype wire
